//--- design/atc_pkg.sv
// ==========================================================
package atc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 16;
  localparam int IRQ_W = 4;
  localparam int STAT_W = 7;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_HALT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_RESTART = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h32;

  // ==========================================================
  // control word fields
  localparam int BIT_FL_EN = 14;
  localparam int BIT_SWEEP_MODE = 13;
  localparam int VLEN_LSB = 9;
  localparam int VLEN_W = 4;
  localparam int FLS_LSB = 5;
  localparam int FLS_W = 4;
  localparam int BIT_SM_CTRL = 4;
  localparam int BIT_ACQ_SEL = 3;
  localparam int BIT_UP_LOCK = 2;
  localparam int BIT_SWEEP_EN = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [VLEN_W-1:0] CNT_ONE = 4'h1;

  // ==========================================================
  // interrupt status bits
  localparam int IRQ_LOCKED = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_FALSE = 2;
  localparam int IRQ_PERIOD = 3;

  // ==========================================================
  // status output bus bits
  localparam int ST_HALTED = 0;
  localparam int ST_ACC_RUN = 1;
  localparam int ST_SWEEP = 2;
  localparam int ST_ACQ_SET = 3;
  localparam int ST_VERIFY = 4;
  localparam int ST_FALSE = 5;
  localparam int ST_LOCK = 6;

  typedef enum logic [3:0] {
    ATC_ACQ = 4'h1,
    ATC_VERIFY = 4'h2,
    ATC_LOCKED = 4'h4,
    ATC_FALSE = 4'h8
  } atc_state_type;

endpackage : atc_pkg

//--- design/atc_acq_track_ctrl.sv
// Added by the designer: the plain strobed port.
module atc_acq_track_ctrl #(
  parameter int SWEEP_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [atc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [atc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [atc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic integ_done,
  input wire logic lock_ovf,
  input wire logic fl_ovf,
  input wire logic compute_tick,
  input wire logic [SWEEP_W-1:0] sweep_in,
  output logic [SWEEP_W-1:0] sweep_to_lag,
  output logic lock_acc_run,
  output logic acq_param_sel,
  output logic fl_acc_enable,
  output logic [atc_pkg::STAT_W-1:0] status_output_bus,
  output logic lock_indication_status_bit,
  output logic irq
);
  import atc_pkg::*;

  // ==========================================================
  // parameter check
  if (SWEEP_W < 1 || SWEEP_W > DATA_W) begin : g_bad_width
    $error("SWEEP_W must lie between 1 and DATA_W");
  end

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    atc_state_type state;
    logic [VLEN_W-1:0] verify_cnt;
    logic [FLS_W-1:0] sweep_cnt;
    logic acc_run;
    logic halt_req;
    logic halted;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic [SWEEP_W-1:0] sweep_out;
    logic [STAT_W-1:0] status;
  } atc_regs_type;

  atc_regs_type q;
  atc_regs_type d;

  logic sm_mode;
  logic wr_ctrl;
  logic [IRQ_W-1:0] ev;
  logic sweep_on;
  logic tick;

  assign sm_mode = q.ctrl[BIT_SM_CTRL];
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  // a period only counts while the accumulator is running
  assign tick = integ_done && q.acc_run;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.rdata = '0;
    ev = '0;
    sweep_on = 1'b0;

    // ---- processor-controlled accumulator ----
    if (!sm_mode) begin
      if (tick) begin
        d.acc_run = 1'b0;
        ev[IRQ_PERIOD] = 1'b1;
      end
    end else begin
      // ---- internal state machine ----
      case (q.state)
        ATC_ACQ: begin
          if (tick && lock_ovf) begin
            if (q.ctrl[VLEN_LSB +: VLEN_W] == '0) begin
              d.state = ATC_LOCKED;
              ev[IRQ_LOCKED] = 1'b1;
            end else begin
              d.state = ATC_VERIFY;
              d.verify_cnt = q.ctrl[VLEN_LSB +: VLEN_W];
            end
          end
        end
        ATC_VERIFY: begin
          if (q.ctrl[BIT_FL_EN] && fl_ovf && q.acc_run) begin
            d.state = ATC_FALSE;
            d.sweep_cnt = q.ctrl[FLS_LSB +: FLS_W];
            ev[IRQ_FALSE] = 1'b1;
          end else if (tick) begin
            if (!lock_ovf) begin
              d.state = ATC_ACQ;
            end else if (q.verify_cnt == CNT_ONE) begin
              d.state = ATC_LOCKED;
              ev[IRQ_LOCKED] = 1'b1;
            end else begin
              d.verify_cnt = q.verify_cnt - CNT_ONE;
            end
          end
        end
        ATC_LOCKED: begin
          if (tick && !lock_ovf) begin
            d.state = ATC_ACQ;
            ev[IRQ_LOST] = 1'b1;
          end
        end
        ATC_FALSE: begin
          sweep_on = 1'b1;
          if (q.ctrl[BIT_SWEEP_MODE] ? tick : (compute_tick && q.acc_run)) begin
            if (q.sweep_cnt <= CNT_ONE) begin
              d.state = ATC_ACQ;
            end else begin
              d.sweep_cnt = q.sweep_cnt - CNT_ONE;
            end
          end
        end
        default: begin
          d.state = ATC_ACQ;
        end
      endcase
      // stop only at the end of the current period
      if (tick && q.halt_req) begin
        d.acc_run = 1'b0;
        d.halted = 1'b1;
        d.halt_req = 1'b0;
      end
    end

    // ---- register writes ----
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          d.ctrl = reg_wdata[CTRL_W-1:0];
          if (!sm_mode && reg_wdata[BIT_SM_CTRL]) begin
            d.state = reg_wdata[BIT_UP_LOCK] ? ATC_LOCKED : ATC_ACQ;
            d.acc_run = !q.halted;
          end
        end
        ADDR_HALT: begin
          d.halt_req = sm_mode;
        end
        ADDR_RESTART: begin
          d.halt_req = 1'b0;
          d.halted = 1'b0;
          d.acc_run = 1'b1;
        end
        ADDR_IRQ_MASK: begin
          d.irq_mask = reg_wdata[IRQ_W-1:0];
        end
        default: begin
          d.irq_mask = q.irq_mask;
        end
      endcase
    end

    // ---- reads; sticky bits clear on read, new events win ----
    d.irq_stat = q.irq_stat | ev;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATE: begin
          d.rdata = {{(DATA_W-4-VLEN_W-FLS_W-3){1'b0}}, q.halted, q.halt_req,
                     q.acc_run, q.sweep_cnt, q.verify_cnt, q.state};
        end
        ADDR_IRQ_STAT: begin
          d.rdata = {{(DATA_W-IRQ_W){1'b0}}, q.irq_stat};
          d.irq_stat = ev;
        end
        ADDR_IRQ_MASK: begin
          d.rdata = {{(DATA_W-IRQ_W){1'b0}}, q.irq_mask};
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end

    // ---- outputs, registered from the next state ----
    if (!d.ctrl[BIT_SM_CTRL]) begin
      sweep_on = d.ctrl[BIT_SWEEP_EN];
    end else begin
      sweep_on = (d.state == ATC_FALSE);
    end
    d.sweep_out = sweep_on ? sweep_in : '0;
    d.status = '0;
    d.status[ST_HALTED] = d.halted;
    d.status[ST_ACC_RUN] = d.acc_run;
    d.status[ST_SWEEP] = sweep_on;
    if (!d.ctrl[BIT_SM_CTRL]) begin
      d.status[ST_ACQ_SET] = d.ctrl[BIT_ACQ_SEL];
      d.status[ST_LOCK] = d.ctrl[BIT_UP_LOCK];
    end else begin
      d.status[ST_ACQ_SET] = (d.state == ATC_ACQ) || (d.state == ATC_FALSE);
      d.status[ST_LOCK] = (d.state == ATC_LOCKED);
      d.status[ST_VERIFY] = (d.state == ATC_VERIFY);
      d.status[ST_FALSE] = (d.state == ATC_FALSE);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q.ctrl <= CTRL_RESET;
      q.state <= ATC_ACQ;
      q.verify_cnt <= '0;
      q.sweep_cnt <= '0;
      q.acc_run <= 1'b0;
      q.halt_req <= 1'b0;
      q.halted <= 1'b0;
      q.irq_stat <= '0;
      q.irq_mask <= '0;
      q.rdata <= '0;
      q.sweep_out <= '0;
      q.status <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = q.rdata;
  assign sweep_to_lag = q.sweep_out;
  assign lock_acc_run = q.status[ST_ACC_RUN];
  assign acq_param_sel = q.status[ST_ACQ_SET];
  assign fl_acc_enable = sm_mode && (q.state == ATC_VERIFY);
  assign status_output_bus = q.status;
  assign lock_indication_status_bit = q.status[ST_LOCK];
  assign irq = |(q.irq_stat & q.irq_mask);

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_fl_force;
    clk_en && sm_mode && q.state == ATC_VERIFY && q.ctrl[BIT_FL_EN] && fl_ovf
      && q.acc_run && !reg_wr |=> q.state == ATC_FALSE && q.status[ST_FALSE];
  endproperty
  a_fl_force:
    assert property (p_fl_force) else $error("false-lock overflow not forced");

  property p_fl_off;
    clk_en && sm_mode && q.state == ATC_VERIFY && !q.ctrl[BIT_FL_EN] && fl_ovf
      && !integ_done && !reg_wr |=> q.state == ATC_VERIFY;
  endproperty
  a_fl_off:
    assert property (p_fl_off) else $error("disabled false lock changed state");

  property p_verify_skip;
    clk_en && sm_mode && q.state == ATC_ACQ && tick && lock_ovf && !reg_wr
      && q.ctrl[VLEN_LSB +: VLEN_W] == '0 |=> q.state == ATC_LOCKED && q.irq_stat[IRQ_LOCKED];
  endproperty
  a_verify_skip:
    assert property (p_verify_skip) else $error("zero verify length not locked");

  property p_verify_hold;
    clk_en && sm_mode && q.state == ATC_VERIFY && tick && lock_ovf && !fl_ovf && !reg_wr
      && q.verify_cnt > CNT_ONE |=> q.state == ATC_VERIFY
      && q.verify_cnt == $past(q.verify_cnt) - CNT_ONE;
  endproperty
  a_verify_hold:
    assert property (p_verify_hold) else $error("verify ended early");

  property p_period_stop;
    clk_en && !sm_mode && tick && !reg_wr |=> !lock_acc_run ##1 (!lock_acc_run || $past(reg_wr));
  endproperty
  a_period_stop:
    assert property (p_period_stop) else $error("accumulator kept running");

  property p_up_lock;
    clk_en && !sm_mode && !reg_wr |=> lock_indication_status_bit == $past(q.ctrl[BIT_UP_LOCK])
      && acq_param_sel == $past(q.ctrl[BIT_ACQ_SEL]);
  endproperty
  a_up_lock:
    assert property (p_up_lock) else $error("processor lock or select not on status");

  property p_handover;
    clk_en && !sm_mode && wr_ctrl && reg_wdata[BIT_SM_CTRL] && reg_wdata[BIT_UP_LOCK]
      |=> q.state == ATC_LOCKED && lock_indication_status_bit;
  endproperty
  a_handover:
    assert property (p_handover) else $error("hand-over did not enter locked");

  property p_sweep_gate;
    clk_en && !sm_mode && !q.ctrl[BIT_SWEEP_EN] && !reg_wr |=> sweep_to_lag == '0;
  endproperty
  a_sweep_gate:
    assert property (p_sweep_gate) else $error("sweep reached lag path while disabled");

  property p_restart;
    clk_en && reg_wr && reg_addr == ADDR_RESTART |=> lock_acc_run && !status_output_bus[ST_HALTED];
  endproperty
  a_restart:
    assert property (p_restart) else $error("restart did not resume accumulator");

  property p_halt_stop;
    clk_en && sm_mode && q.halt_req && tick && !reg_wr
      |=> !lock_acc_run && status_output_bus[ST_HALTED];
  endproperty
  a_halt_stop:
    assert property (p_halt_stop) else $error("halt request did not stop accumulator");

  property p_sweep_hold;
    clk_en && sm_mode && q.state == ATC_FALSE && q.ctrl[BIT_SWEEP_MODE] && !integ_done
      && !reg_wr |=> q.state == ATC_FALSE && sweep_to_lag == $past(sweep_in);
  endproperty
  a_sweep_hold:
    assert property (p_sweep_hold) else $error("continuous sweep ended without a period");

  property p_stepped_hold;
    clk_en && sm_mode && q.state == ATC_FALSE && !q.ctrl[BIT_SWEEP_MODE] && !compute_tick
      && !reg_wr |=> q.state == ATC_FALSE;
  endproperty
  a_stepped_hold:
    assert property (p_stepped_hold) else $error("stepped sweep ended without a compute cycle");

  c_locked: cover property (clk_en && sm_mode && q.state == ATC_VERIFY ##1 q.state == ATC_LOCKED);
  c_false: cover property (q.state == ATC_FALSE ##[1:40] q.state == ATC_ACQ);
  c_halted: cover property (clk_en && q.halted ##[1:20] reg_wr && reg_addr == ADDR_RESTART);
  c_irq: cover property (irq ##1 reg_rd && reg_addr == ADDR_IRQ_STAT);

endmodule : atc_acq_track_ctrl

//--- testbench/acquisition_tracking_control_tb.sv
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module acquisition_tracking_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atc_pkg::*;
  localparam int SW = 16;

  typedef struct {
    logic [15:0] ctrl;
    logic [SW-1:0] sw;
    logic acq;
    logic lk;
    logic [SW-1:0] exp_sw;
  } atc_row_type;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic integ_done = 1'b0;
  logic lock_ovf = 1'b0;
  logic fl_ovf = 1'b0;
  logic compute_tick = 1'b0;
  logic [SW-1:0] sweep_in = '0;
  logic [SW-1:0] sweep_to_lag;
  logic lock_acc_run;
  logic acq_param_sel;
  logic fl_acc_enable;
  logic [STAT_W-1:0] status_output_bus;
  logic lock_indication_status_bit;
  logic irq;
  logic [DATA_W-1:0] v;
  int fails = 0;
  int n_checks = 0;
  atc_row_type rows [6];

  atc_acq_track_ctrl #(.SWEEP_W(SW)) dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .integ_done(integ_done), .lock_ovf(lock_ovf), .fl_ovf(fl_ovf),
    .compute_tick(compute_tick), .sweep_in(sweep_in), .sweep_to_lag(sweep_to_lag),
    .lock_acc_run(lock_acc_run), .acq_param_sel(acq_param_sel),
    .fl_acc_enable(fl_acc_enable), .status_output_bus(status_output_bus),
    .lock_indication_status_bit(lock_indication_status_bit), .irq(irq)
  );

  always #25 sys_clk = ~sys_clk;

  // ==========================================================
  // bus and event tasks
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic ev(input logic d, input logic l, input logic f, input logic t);
    @(posedge sys_clk);
    integ_done <= d;
    lock_ovf <= l;
    fl_ovf <= f;
    compute_tick <= t;
    @(posedge sys_clk);
    integ_done <= 1'b0;
    lock_ovf <= 1'b0;
    fl_ovf <= 1'b0;
    compute_tick <= 1'b0;
    #1;
  endtask : ev

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{16'h0000, 16'h1234, 1'b0, 1'b0, 16'h0000};
    rows[1] = '{16'h0008, 16'h1234, 1'b1, 1'b0, 16'h0000};
    rows[2] = '{16'h0004, 16'hA5A5, 1'b0, 1'b1, 16'h0000};
    rows[3] = '{16'h0001, 16'hA5A5, 1'b0, 1'b0, 16'hA5A5};
    rows[4] = '{16'h000D, 16'h7E01, 1'b1, 1'b1, 16'h7E01};
    rows[5] = '{16'h2001, 16'h0FF0, 1'b0, 1'b0, 16'h0FF0};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("status_bus", 7'h00, status_output_bus);
    `CHK("irq", 1'b0, irq);
    // processor period: run, stop at period end, rollover ignored
    wr(ADDR_RESTART, 32'h0000_0000);
    `CHK("acc_run", 1'b1, lock_acc_run);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    `CHK("acc_run", 1'b0, lock_acc_run);
    `CHK("lock_bit", 1'b0, lock_indication_status_bit);
    wr(ADDR_IRQ_MASK, 32'h0000_0008);
    `CHK("irq", 1'b1, irq);
    rd(ADDR_IRQ_STAT, v);
    `CHK("irq_stat", 4'h8, v[3:0]);
    `CHK("irq", 1'b0, irq);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("irq", 1'b0, irq);
    rd(ADDR_IRQ_MASK, v);
    `CHK("irq_mask", 32'h0000_0008, v);
    rd(8'h55, v);
    `CHK("unmapped", 32'h0000_0000, v);
    rd(ADDR_CTRL, v);
    `CHK("ctrl_read", 32'h0000_0000, v);
    // processor control fields, all acting on one write
    foreach (rows[i]) begin
      @(posedge sys_clk);
      sweep_in <= rows[i].sw;
      wr(ADDR_CTRL, {16'h0000, rows[i].ctrl});
      `CHK("acq_sel", rows[i].acq, acq_param_sel);
      `CHK("st_acq", rows[i].acq, status_output_bus[ST_ACQ_SET]);
      `CHK("lock_bit", rows[i].lk, lock_indication_status_bit);
      `CHK("st_lock", rows[i].lk, status_output_bus[ST_LOCK]);
      `CHK("sweep_lag", rows[i].exp_sw, sweep_to_lag);
    end
    wr(ADDR_CTRL, 32'h0000_0014);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h4, v[3:0]);
    // state machine with verify length 2
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0410);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h1, v[3:0]);
    `CHK("acc_run", 1'b1, lock_acc_run);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h2, v[3:0]);
    `CHK("fl_acc_en", 1'b1, fl_acc_enable);
    `CHK("acq_sel", 1'b0, acq_param_sel);
    `CHK("st_verify", 1'b1, status_output_bus[ST_VERIFY]);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h2, v[3:0]);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h4, v[3:0]);
    rd(ADDR_IRQ_STAT, v);
    `CHK("irq_locked", 1'b1, v[IRQ_LOCKED]);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(ADDR_IRQ_STAT, v);
    `CHK("irq_lost", 1'b1, v[IRQ_LOST]);
    // false lock disabled, stepped sweep, continuous sweep; sweep field 3
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_CTRL, (k == 0) ? 32'h0000_0470
         : ((k == 2) ? 32'h0000_6470 : 32'h0000_4470));
      ev(1'b1, 1'b1, 1'b0, 1'b0);
      ev(1'b0, 1'b0, 1'b1, 1'b0);
      rd(ADDR_STATE, v);
      `CHK("state", (k == 0) ? 4'h2 : 4'h8, v[3:0]);
      if (k > 0) begin
        `CHK("st_false", 1'b1, status_output_bus[ST_FALSE]);
        `CHK("st_sweep", 1'b1, status_output_bus[ST_SWEEP]);
        `CHK("sweep_lag", 16'h0FF0, sweep_to_lag);
        for (int j = 1; j <= 3; j++) begin
          ev(k == 2, 1'b0, 1'b0, k == 1);
          rd(ADDR_STATE, v);
          `CHK("sweep_state", (j < 3) ? 4'h8 : 4'h1, v[3:0]);
        end
      end
    end
    rd(ADDR_IRQ_STAT, v);
    `CHK("irq_false", 1'b1, v[IRQ_FALSE]);
    // zero verify length, then halt for reading and restart
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0010);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    rd(ADDR_STATE, v);
    `CHK("state", 4'h4, v[3:0]);
    wr(ADDR_HALT, 32'h0000_0000);
    rd(ADDR_STATE, v);
    `CHK("halt_req", 1'b1, v[13]);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    `CHK("acc_run", 1'b0, lock_acc_run);
    `CHK("st_halted", 1'b1, status_output_bus[ST_HALTED]);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATE, v);
    `CHK("halted_state", 4'h4, v[3:0]);
    `CHK("halted_flags", 3'b100, v[14:12]);
    wr(ADDR_RESTART, 32'h0000_0000);
    `CHK("acc_run", 1'b1, lock_acc_run);
    `CHK("st_halted", 1'b0, status_output_bus[ST_HALTED]);
    // frozen clock enable: a lost period must not leave locked
    @(posedge sys_clk);
    clk_en <= 1'b0;
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(ADDR_STATE, v);
    `CHK("frozen_state", 4'h4, v[3:0]);
    // reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("rst_status", 7'h00, status_output_bus);
    `CHK("rst_sweep", 16'h0000, sweep_to_lag);
    `CHK("rst_irq", 1'b0, irq);
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_STATE, v);
    `CHK("rst_state", 32'h0000_0001, v);
    stop_test();
  end
endmodule : acquisition_tracking_control_tb
